// ### sfl_host_model.sv
// Host-side SPI master model for the framed link, mode 0, clock running only within frames.
`timescale 1ns/1ns
`default_nettype none
module sfl_host_model
(
  // SPI link, master side
  output logic      spi_sclk,
  output logic      slave_select_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial
  begin
    spi_sclk       = 1'b0;
    slave_select_n = 1'b0;
    spi_mosi       = 1'b0;
    // A short low pulse on select makes its rise clear the link-side shift state at start-up.
    #1 slave_select_n = 1'b1;
  end

  // Select moves only with the clock at rest; a released data line shows the inverse of its last bit.
  task sel(input logic v);
    #80 slave_select_n = v;
    if (v)
      spi_mosi = ~spi_mosi;
    #80;
  endtask

  // One byte, MSB first; the data is sampled as the clock rises.
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--)
    begin
      spi_mosi = tx[b];
      #80 rx[b] = spi_miso;
      spi_sclk = 1'b1;
      #80 spi_sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### sfl_link.sv
// Framed SPI slave link with attention and wake handshakes.
`timescale 1ns/1ns
`default_nettype none
`include "sfl_regs.svh"
module sfl_link
  import sfl_pkg::*;
#(
  parameter int ADDR_W = 7
)
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // SPI link, slave side
  input  wire logic              spi_sclk,
  input  wire logic              slave_select_n,
  input  wire logic              spi_mosi,
  output logic                   spi_miso,
  // Handshake lines
  output logic                   host_attention_n,
  input  wire logic              wake_request_n,
  // Commands toward the stack
  output logic [7:0]             cmd_byte,
  output logic                   cmd_byte_valid,
  output logic                   cmd_done,
  output sfl_frame_t             cmd_info,
  // Responses from the stack
  input  wire logic              out_pending,
  input  wire logic              resp_wr_en,
  input  wire logic [ADDR_W-1:0] resp_wr_addr,
  input  wire logic [7:0]        resp_wr_data,
  input  wire logic              resp_start,
  input  wire sfl_frame_t        resp_info,
  output logic                   resp_sent
);

  localparam logic [9:0] REST_CYC = 10'(`SFL_T_REST_US * `SFL_CLK_MHZ);
  localparam logic [9:0] REL_CYC  = 10'(`SFL_T_REL_US * `SFL_CLK_MHZ);
  localparam logic [9:0] GAP_CYC  = 10'(`SFL_T_GAP_US * `SFL_CLK_MHZ);
  localparam int         REL_HI   = `SFL_T_REL_US * `SFL_CLK_MHZ + 4;

  logic       link_rst_reg;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] rx_shift_reg, rx_shift_next;
  logic [7:0] tx_shift_reg, tx_shift_next;
  logic [7:0] rx_byte_reg, rx_byte_next;
  logic       rx_tog_reg, rx_tog_next;
  logic       byte_end;
  logic [7:0] tx_word_reg, tx_word_next;

  // Link side: sample on the rising edge in both SPI modes.
  always_comb
  begin
    byte_end      = (bit_cnt_reg == `SFL_BIT_LAST);
    bit_cnt_next  = bit_cnt_reg + 3'h1;
    rx_shift_next = {rx_shift_reg[6:0], spi_mosi};
    tx_shift_next = byte_end ? tx_word_reg : {tx_shift_reg[6:0], 1'b1};
    rx_tog_next   = rx_tog_reg ^ byte_end;
    rx_byte_next  = byte_end ? rx_shift_next : rx_byte_reg;
  end

  // Select idle restarts the bit position, so a frame cut mid-byte cannot misalign the next one.
  always_ff @(posedge spi_sclk or posedge slave_select_n)
  begin
    if (slave_select_n)
    begin
      bit_cnt_reg  <= 3'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= `SFL_BYTE_IDLE;
    end
    else
    begin
      bit_cnt_reg  <= bit_cnt_next;
      rx_shift_reg <= rx_shift_next;
      tx_shift_reg <= tx_shift_next;
    end
  end

  // The byte toggle survives select idle; clearing it there would race the last byte of a frame.
  always_ff @(posedge spi_sclk or posedge link_rst_reg)
  begin
    if (link_rst_reg)
    begin
      rx_tog_reg  <= 1'b0;
      rx_byte_reg <= 8'h00;
    end
    else
    begin
      rx_tog_reg  <= rx_tog_next;
      rx_byte_reg <= rx_byte_next;
    end
  end

  assign spi_miso = tx_shift_reg[7];

  // Crossing into the core clock.
  logic       ss_s, wake_s, tog_s;
  logic [1:0] ss_d_reg;
  logic       wake_d_reg, tog_d_reg;
  logic       ss_idle, rx_edge, wake_fall, wake_rise;

  sfl_sync #(.WIDTH(3), .RST_VAL(`SFL_SYNC_RST)) u_sync (
    .clk  (core_clk),
    .rst  (sys_rst),
    .din  ({slave_select_n, wake_request_n, rx_tog_reg}),
    .dout ({ss_s, wake_s, tog_s})
  );

  // Select idle is delayed past the byte toggle so the final byte of a frame is always seen first.
  always_ff @(posedge core_clk)
  begin
    link_rst_reg <= sys_rst;
    if (sys_rst)
    begin
      ss_d_reg   <= 2'h3;
      wake_d_reg <= 1'b1;
      tog_d_reg  <= 1'b0;
    end
    else
    begin
      ss_d_reg   <= {ss_d_reg[0], ss_s};
      wake_d_reg <= wake_s;
      tog_d_reg  <= tog_s;
    end
  end

  assign ss_idle   = ss_d_reg[1];
  assign rx_edge   = tog_s ^ tog_d_reg;
  assign wake_fall = !wake_s && wake_d_reg;
  assign wake_rise = wake_s && !wake_d_reg;

  // Frame engine.
  sfl_state_t state_reg, state_next;
  logic [7:0] idx_reg, idx_next, ftype_reg, ftype_next, flen_reg, flen_next;
  logic [7:0] err_code_reg, err_code_next;
  logic       err_valid_reg, err_valid_next, answer_err_reg, answer_err_next;
  logic       resp_ready_reg, resp_ready_next;
  sfl_frame_t rinfo_reg, rinfo_next, cmd_info_next;
  logic [1:0] load_reg, load_next;
  logic [7:0] cmd_byte_next;
  logic       cmd_byte_valid_next, cmd_done_next, resp_sent_next;
  logic       err_set, err_clr;
  logic [7:0] err_val, term_pos, total, out_byte, mem_rdata;

  sfl_resp_mem #(.WIDTH(8), .ADDR_W(ADDR_W)) u_mem (
    .clk     (core_clk),
    .wr_en   (resp_wr_en),
    .wr_addr (resp_wr_addr),
    .wr_data (resp_wr_data),
    .rd_addr (ADDR_W'(idx_reg - `SFL_PAY_OFS)),
    .rd_data (mem_rdata)
  );

  always_comb
  begin
    state_next          = state_reg;
    idx_next            = idx_reg;
    ftype_next          = ftype_reg;
    flen_next           = flen_reg;
    err_code_next       = err_code_reg;
    answer_err_next     = answer_err_reg;
    resp_ready_next     = resp_ready_reg;
    rinfo_next          = rinfo_reg;
    tx_word_next        = tx_word_reg;
    load_next           = {load_reg[0], 1'b0};
    cmd_byte_next       = cmd_byte;
    cmd_byte_valid_next = 1'b0;
    cmd_done_next       = 1'b0;
    cmd_info_next       = cmd_info;
    resp_sent_next      = 1'b0;
    err_set             = 1'b0;
    err_clr             = 1'b0;
    err_val             = `SFL_ERR_ABORT;
    term_pos = (ftype_reg == `SFL_TYPE_STACK) ? flen_reg + `SFL_PAY_OFS : `SFL_IDX_LEN;
    total = answer_err_reg ? `SFL_FRAME_ERR :
            (rinfo_reg.len == 8'h00) ? `SFL_FRAME_SHORT : rinfo_reg.len + `SFL_FRAME_OVERHEAD;
    if (idx_reg >= total)
      out_byte = `SFL_BYTE_IDLE;
    else if (idx_reg == `SFL_IDX_TYPE)
      out_byte = answer_err_reg ? err_code_reg : rinfo_reg.kind;
    else if (idx_reg == total - 8'h01)
      out_byte = `SFL_BYTE_TERM;
    else if (idx_reg == `SFL_IDX_LEN)
      out_byte = answer_err_reg ? `SFL_ERR_DETAIL : rinfo_reg.len;
    else
      out_byte = mem_rdata;
    unique case (state_reg)
      ST_IDLE:
        if (!ss_idle)
        begin
          state_next      = ST_CMD;
          idx_next        = `SFL_IDX_TYPE;
          answer_err_next = 1'b0;
          resp_ready_next = 1'b0;
        end
      ST_CMD:
        if (ss_idle)
        begin
          state_next = ST_IDLE;
          err_set    = 1'b1;
        end
        else if (rx_edge)
        begin
          idx_next = idx_reg + 8'h01;
          if (idx_reg == `SFL_IDX_TYPE)
          begin
            ftype_next = rx_byte_reg;
            flen_next  = 8'h00;
          end
          else if (ftype_reg == `SFL_TYPE_STACK && idx_reg == `SFL_IDX_LEN)
          begin
            flen_next = rx_byte_reg;
            if (rx_byte_reg > `SFL_LEN_MAX)
            begin
              err_set    = 1'b1;
              err_val    = `SFL_ERR_OVERSIZE;
              state_next = ST_DROP;
            end
          end
          else if (idx_reg == term_pos)
          begin
            state_next = ST_WAIT;
            if (rx_byte_reg != `SFL_BYTE_TERM)
            begin
              err_set         = 1'b1;
              err_val         = `SFL_ERR_NO_TERM;
              answer_err_next = 1'b1;
              resp_ready_next = 1'b1;
            end
            else if (err_valid_reg)
            begin
              answer_err_next = 1'b1;
              resp_ready_next = 1'b1;
            end
            else
            begin
              cmd_done_next = 1'b1;
              cmd_info_next = '{kind: ftype_reg, len: flen_reg};
            end
          end
          else
          begin
            cmd_byte_next       = rx_byte_reg;
            cmd_byte_valid_next = 1'b1;
          end
        end
      ST_WAIT:
        if (ss_idle)
        begin
          state_next = ST_IDLE;
          err_set    = 1'b1;
        end
        else if (resp_ready_reg && rx_edge)
        begin
          state_next = ST_RESP;
          idx_next   = `SFL_IDX_TYPE;
          load_next  = {load_reg[0], 1'b1};
        end
        else if (resp_start && !resp_ready_reg)
        begin
          resp_ready_next = 1'b1;
          rinfo_next      = resp_info;
        end
      ST_RESP:
      begin
        if (ss_idle)
        begin
          state_next = ST_IDLE;
          err_set    = 1'b1;
        end
        else if (rx_edge && idx_reg == total)
        begin
          state_next     = ST_DONE;
          resp_sent_next = 1'b1;
          err_clr        = answer_err_reg;
        end
        else if (rx_edge)
        begin
          idx_next  = idx_reg + 8'h01;
          load_next = {load_reg[0], 1'b1};
        end
        if (load_reg[1])
          tx_word_next = out_byte;
      end
      ST_DROP, ST_DONE:
        if (ss_idle)
          state_next = ST_IDLE;
    endcase
    if (state_next != ST_RESP)
      tx_word_next = `SFL_BYTE_IDLE;
    err_valid_next = (err_valid_reg && !err_clr) || err_set;
    if (err_set && !err_valid_reg)
      err_code_next = err_val;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_reg      <= ST_IDLE;
      idx_reg        <= 8'h00;
      ftype_reg      <= 8'h00;
      flen_reg       <= 8'h00;
      err_code_reg   <= 8'h00;
      err_valid_reg  <= 1'b0;
      answer_err_reg <= 1'b0;
      resp_ready_reg <= 1'b0;
      rinfo_reg      <= '0;
      tx_word_reg    <= `SFL_BYTE_IDLE;
      load_reg       <= 2'h0;
      cmd_byte       <= 8'h00;
      cmd_byte_valid <= 1'b0;
      cmd_done       <= 1'b0;
      cmd_info       <= '0;
      resp_sent      <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      idx_reg        <= idx_next;
      ftype_reg      <= ftype_next;
      flen_reg       <= flen_next;
      err_code_reg   <= err_code_next;
      err_valid_reg  <= err_valid_next;
      answer_err_reg <= answer_err_next;
      resp_ready_reg <= resp_ready_next;
      rinfo_reg      <= rinfo_next;
      tx_word_reg    <= tx_word_next;
      load_reg       <= load_next;
      cmd_byte       <= cmd_byte_next;
      cmd_byte_valid <= cmd_byte_valid_next;
      cmd_done       <= cmd_done_next;
      cmd_info       <= cmd_info_next;
      resp_sent      <= resp_sent_next;
    end
  end

  // Attention line.
  logic       attn_reg, attn_next, rel_arm_reg, rel_arm_next;
  logic       wake_req_reg, wake_req_next, wake_attn_reg, wake_attn_next;
  logic [9:0] rest_cnt_reg, rest_cnt_next, gap_cnt_reg, gap_cnt_next, rel_cnt_reg, rel_cnt_next;
  logic       rest_ok, gap_ok, want;

  always_comb
  begin
    rest_ok        = (rest_cnt_reg == REST_CYC);
    gap_ok         = (gap_cnt_reg == GAP_CYC);
    rest_cnt_next  = (attn_reg || rest_ok) ? (attn_reg ? 10'h000 : rest_cnt_reg) : rest_cnt_reg + 10'h001;
    gap_cnt_next   = (state_reg != ST_IDLE) ? 10'h000 : (gap_ok ? gap_cnt_reg : gap_cnt_reg + 10'h001);
    rel_cnt_next   = rel_arm_reg ? rel_cnt_reg + 10'h001 : 10'h000;
    want = (wake_req_reg && state_reg == ST_IDLE)
           || (state_reg == ST_WAIT && resp_ready_reg)
           || (state_reg == ST_IDLE && gap_ok && (out_pending || err_valid_reg));
    attn_next      = attn_reg;
    rel_arm_next   = rel_arm_reg;
    wake_attn_next = wake_attn_reg || (attn_reg && wake_fall);
    wake_req_next  = wake_req_reg || (wake_fall && !attn_reg);
    if (!attn_reg)
    begin
      if (want && rest_ok)
      begin
        attn_next      = 1'b1;
        rel_arm_next   = 1'b0;
        wake_attn_next = wake_req_reg;
        wake_req_next  = wake_fall;
      end
    end
    else if ((rel_arm_reg && rel_cnt_reg == REL_CYC) || (wake_attn_reg && wake_rise))
    begin
      attn_next      = 1'b0;
      rel_arm_next   = 1'b0;
      wake_attn_next = 1'b0;
    end
    else if (rx_edge)
      rel_arm_next = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      attn_reg      <= 1'b0;
      rel_arm_reg   <= 1'b0;
      wake_req_reg  <= 1'b0;
      wake_attn_reg <= 1'b0;
      rest_cnt_reg  <= 10'h000;
      gap_cnt_reg   <= 10'h000;
      rel_cnt_reg   <= 10'h000;
    end
    else
    begin
      attn_reg      <= attn_next;
      rel_arm_reg   <= rel_arm_next;
      wake_req_reg  <= wake_req_next;
      wake_attn_reg <= wake_attn_next;
      rest_cnt_reg  <= rest_cnt_next;
      gap_cnt_reg   <= gap_cnt_next;
      rel_cnt_reg   <= rel_cnt_next;
    end
  end

  assign host_attention_n = !attn_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_byte_while_on;
    attn_reg && rx_edge && !rel_arm_reg && !wake_attn_reg;
  endsequence

  chk_attn_release: assert property (s_byte_while_on |-> ##[1:REL_HI] !attn_reg)
    else $error("attention not released after a received byte");
  chk_attn_held: assert property (s_byte_while_on |-> ##1 attn_reg [*8])
    else $error("attention released too early after a byte");
  chk_attn_rest: assert property (!attn_reg && attn_next |-> rest_cnt_reg == REST_CYC)
    else $error("attention reasserted before its idle time");
  chk_wake_release: assert property (attn_reg && wake_attn_reg && wake_rise |=> !attn_reg)
    else $error("attention held after wake release");
  chk_cmd_ff: assert property (state_reg inside {ST_CMD, ST_DROP, ST_WAIT} |-> tx_word_reg == `SFL_BYTE_IDLE)
    else $error("non-idle byte offered outside a response");
  chk_err_first: assert property (err_valid_reg && !err_clr |=> err_valid_reg && $stable(err_code_reg))
    else $error("pending error changed before being reported");
  chk_oversize: assert property (state_reg == ST_CMD && !ss_idle && rx_edge && idx_reg == `SFL_IDX_LEN
      && ftype_reg == `SFL_TYPE_STACK && rx_byte_reg > `SFL_LEN_MAX && !err_valid_reg
      |=> state_reg == ST_DROP && err_code_reg == `SFL_ERR_OVERSIZE)
    else $error("oversize length not dropped");
  chk_abort: assert property (state_reg inside {ST_CMD, ST_WAIT} && ss_idle && !err_valid_reg
      |=> state_reg == ST_IDLE && err_code_reg == `SFL_ERR_ABORT)
    else $error("early select release not flagged");
  chk_no_term: assert property (state_reg == ST_CMD && !ss_idle && rx_edge && idx_reg == term_pos
      && idx_reg != `SFL_IDX_TYPE && rx_byte_reg != `SFL_BYTE_TERM |=> resp_ready_reg && answer_err_reg)
    else $error("missing end marker not answered");
  chk_resp_term: assert property (state_reg == ST_RESP && load_reg[1] && idx_reg == total - 8'h01
      && state_next == ST_RESP |=> tx_word_reg == `SFL_BYTE_TERM)
    else $error("response not closed by end marker");

endmodule
`default_nettype wire

// ### sfl_pkg.sv
// Types shared by the framed SPI slave link.
`default_nettype none
package sfl_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_DROP, ST_WAIT, ST_RESP, ST_DONE} sfl_state_t;

  typedef struct packed {
    logic [7:0] kind;
    logic [7:0] len;
  } sfl_frame_t;

endpackage
`default_nettype wire

// ### sfl_regs.svh
// Constants of the framed SPI slave link: frame bytes, error codes and timing figures.
// Behaviour
// - Attention falls when output waits for host.
// - Attention releases after a received byte.
// - Attention stays idle at least 10 us.
// - Leftover output reasserts attention after select idles.
// - Wake makes device assert attention when ready.
// - Attention releases within 25 us of wake release.
// - Only the first of several errors reported.
// - Length above 125 drops command, flags oversize.
// - Early select release aborts, flags abort error.
// - Missing end marker answered at once.
// - Idle bytes out are 0xFF; stray input ignored.
// - Frame is type, optional length, payload, marker.
// - Length byte counts payload only, 2 to 125; the link flags only lengths above 125 and takes 0 and 1.
// - Every frame ends with marker byte 0xA7.
// - Attention releases 13 to 75 us after command.
// - Attention reasserts 25 to 800 us after transaction.
// - Attention and wake lines are active low.
// - SPI mode 0 or 3, rising-edge sampling.
// - Wait section sends 0xFF until response starts.
// - Error responses carry error type and error byte.
`ifndef SFL_REGS_SVH
`define SFL_REGS_SVH
`define SFL_CLK_MHZ        20
`define SFL_T_REST_US      10
`define SFL_T_REL_US       13
`define SFL_T_GAP_US       25
`define SFL_BYTE_IDLE      8'hFF
`define SFL_BYTE_TERM      8'hA7
`define SFL_TYPE_STACK     8'hFE
`define SFL_LEN_MAX        8'h7D
`define SFL_ERR_OVERSIZE   8'h01
`define SFL_ERR_ABORT      8'h02
`define SFL_ERR_NO_TERM    8'h03
`define SFL_ERR_DETAIL     8'h00
`define SFL_BIT_LAST       3'h7
`define SFL_IDX_TYPE       8'h00
`define SFL_IDX_LEN        8'h01
`define SFL_PAY_OFS        8'h02
`define SFL_FRAME_SHORT    8'h02
`define SFL_FRAME_ERR      8'h03
`define SFL_FRAME_OVERHEAD 8'h03
`define SFL_SYNC_RST       3'h6
`endif

// ### sfl_resp_mem.sv
// Response payload memory with a registered read port.
`timescale 1ns/1ns
`default_nettype none
module sfl_resp_mem
#(
  parameter int WIDTH  = 8,
  parameter int ADDR_W = 7
)
(
  // Clock
  input  wire logic              clk,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]  wr_data,
  // Read port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [WIDTH-1:0]  rd_data
);

  logic [WIDTH-1:0] mem_reg [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= mem_reg[rd_addr];
  end

endmodule
`default_nettype wire

// ### sfl_sync.sv
// Two-flop level synchroniser into the core clock domain.
`timescale 1ns/1ns
`default_nettype none
module sfl_sync
#(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1_reg <= RST_VAL;
      stage2_reg <= RST_VAL;
    end
    else
    begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
    end
  end

  assign dout = stage2_reg;

endmodule
`default_nettype wire

// ### tb_sfl_link.sv
// Self-checking testbench of the framed SPI slave link.
`timescale 1ns/1ns
`default_nettype none
module tb_sfl_link
  import sfl_pkg::*;
;
  wire logic   sclk;
  wire logic   ss_n;
  wire logic   mosi;
  wire logic   miso;
  wire logic   att_n;
  logic        core_clk = 1'b0;
  logic        sys_rst;
  logic        wake_n;
  logic        out_pend;
  logic        wr_en;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        rs;
  sfl_frame_t  rinfo;
  logic [7:0]  cbyte;
  logic        cvalid;
  logic        cdone;
  logic        rsent;
  sfl_frame_t  cinfo;
  logic [31:0] seed = 32'h23;
  logic [7:0]  got[$];
  int          nsent = 0;
  int          ndone = 0;
  int          mismatches = 0;
  int          n_tests = 0;

  always #25 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    if (cvalid === 1'b1)
      got.push_back(cbyte);
    if (rsent === 1'b1)
      nsent++;
    if (cdone === 1'b1)
      ndone++;
  end

  sfl_link uut (.core_clk(core_clk), .sys_rst(sys_rst), .spi_sclk(sclk), .slave_select_n(ss_n),
    .spi_mosi(mosi), .spi_miso(miso), .host_attention_n(att_n), .wake_request_n(wake_n),
    .cmd_byte(cbyte), .cmd_byte_valid(cvalid), .cmd_done(cdone), .cmd_info(cinfo),
    .out_pending(out_pend), .resp_wr_en(wr_en), .resp_wr_addr(wr_addr), .resp_wr_data(wr_data),
    .resp_start(rs), .resp_info(rinfo), .resp_sent(rsent));

  sfl_host_model host (.spi_sclk(sclk), .slave_select_n(ss_n), .spi_mosi(mosi), .spi_miso(miso));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task complete_run();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task wait_att(input logic lvl, input int lim, output int n);
    n = 0;
    while (att_n !== lvl)
    begin
      @(negedge core_clk);
      n++;
      if (n > lim)
      begin
        mismatches++;
        $display("BAD attention expected %b seen %b", lvl, att_n);
        complete_run();
      end
    end
  endtask

  // Pending attention is fetched at once; otherwise the wake handshake replaces the long spacing.
  task gap();
    int n;
    for (n = 0; n < 1200 && att_n !== 1'b0; n++)
      @(negedge core_clk);
    if (att_n !== 1'b0)
    begin
      wake_n = 1'b0;
      wait_att(1'b0, 600, n);
      wake_n = 1'b1;
      wait_att(1'b1, 500, n);
      chk("wake release", 16'(n <= 8), 16'h0001);
    end
  endtask

  task poll(input logic [7:0] e[$]);
    logic [7:0] rx;
    rx = 8'hFF;
    for (int k = 0; k < 60 && rx === 8'hFF; k++)
      host.xfer(8'hFF, rx);
    chk("resp type", rx, e[0]);
    for (int i = 1; i < e.size(); i++)
    begin
      host.xfer(8'hFF, rx);
      chk("resp byte", rx, e[i]);
    end
    host.xfer(8'h5A, rx);
    chk("surplus", rx, 8'hFF);
  endtask

  task answer(input logic [7:0] c[$], input logic [7:0] e[$]);
    int n;
    repeat (20) @(negedge core_clk);
    chk("cmd kind", cinfo.kind, c[0]);
    if (c[0] === 8'hFE)
    begin
      chk("cmd len", cinfo.len, c[1]);
      chk("cmd count", 16'(got.size()), c[1]);
      foreach (got[i])
        chk("cmd byte", got[i], c[i + 2]);
    end
    for (int i = 2; i + 1 < e.size(); i++)
    begin
      wr_en = 1'b1;
      wr_addr = 7'(i - 2);
      wr_data = e[i];
      @(negedge core_clk);
    end
    wr_en = 1'b0;
    // The answer waits until attention has rested, so that a fresh falling edge can announce it.
    wait_att(1'b1, 600, n);
    repeat (220) @(negedge core_clk);
    rinfo = {e[0], (e.size() > 2) ? e[1] : 8'h00};
    rs = 1'b1;
    @(negedge core_clk);
    rs = 1'b0;
    wait_att(1'b0, 600, n);
    wait_att(1'b1, 1500, n);
    chk("att release", 16'(n >= 250), 16'h0001);
  endtask

  task txn(input logic [7:0] c[$], input logic [7:0] e[$], input logic gen);
    logic [7:0] rx;
    int         s;
    int         d;
    int         n;
    s = nsent;
    d = ndone;
    got.delete();
    host.sel(1'b0);
    foreach (c[i])
    begin
      host.xfer(c[i], rx);
      chk("cmd section", rx, 8'hFF);
    end
    fork
      poll(e);
      if (gen) answer(c, e);
    join
    host.sel(1'b1);
    repeat (8) @(negedge core_clk);
    chk("resp sent", 16'(nsent - s), 16'h0001);
    chk("cmd done", 16'(ndone - d), 16'(gen));
    // A stale attention is let go here, so the next spacing sees only fresh output.
    wait_att(1'b1, 1600, n);
  endtask

  initial
  begin
    logic [7:0] c[$];
    logic [7:0] e[$];
    logic [7:0] rx;
    int         n;
    int         l;
    sys_rst  = 1'b1;
    wake_n   = 1'b1;
    out_pend = 1'b0;
    wr_en    = 1'b0;
    wr_addr  = 7'h00;
    wr_data  = 8'h00;
    rs       = 1'b0;
    rinfo    = '0;
    repeat (12) @(negedge core_clk);
    sys_rst = 1'b0;
    chk("att idle", att_n, 1'b1);
    chk("miso idle", miso, 1'b1);
    repeat (4) @(negedge core_clk);
    for (int k = 0; k < 2; k++)
    begin
      seed = xs(seed);
      l = (k == 0) ? 125 : 2 + seed % 8;
      c = {8'hFE, 8'(l)};
      e = {8'hFE, 8'(l)};
      for (int i = 0; i < l; i++)
      begin
        seed = xs(seed);
        c.push_back(seed[7:0]);
        e.push_back(seed[15:8]);
      end
      c.push_back(8'hA7);
      e.push_back(8'hA7);
      gap();
      txn(c, e, 1'b1);
      if (k == 0)
      begin
        out_pend = 1'b1;
        wait_att(1'b0, 16000, n);
        chk("att after txn", 16'(n >= 450), 16'h0001);
        out_pend = 1'b0;
      end
    end
    gap();
    txn('{8'h0A, 8'h55}, '{8'h03, 8'h00, 8'hA7}, 1'b0);
    gap();
    host.sel(1'b0);
    host.xfer(8'hFE, rx);
    host.xfer(8'h7E, rx);
    host.xfer(8'h11, rx);
    host.sel(1'b1);
    wait_att(1'b0, 1200, n);
    host.sel(1'b0);
    host.xfer(8'h0B, rx);
    host.sel(1'b1);
    wait_att(1'b1, 600, n);
    gap();
    txn('{8'h0B, 8'hA7}, '{8'h01, 8'h00, 8'hA7}, 1'b0);
    gap();
    host.sel(1'b0);
    host.xfer(8'h0A, rx);
    host.sel(1'b1);
    wait_att(1'b0, 1200, n);
    txn('{8'h0A, 8'hA7}, '{8'h02, 8'h00, 8'hA7}, 1'b0);
    gap();
    txn('{8'h0B, 8'hA7}, '{8'hC1, 8'hA7}, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
